// ### logic/cdd_pkg.sv
// package: constants and carriers for the double-decrement and interrupt-disable datapath
// How it works
// - double-decrement subtracts two from destination, writes difference back, old value kept as saved original
// - negative flag follows the result's top bit after a double-decrement
// - zero flag set only when the original destination held two
// - carry cleared when original was zero or one, set otherwise
// - word form: overflow set only for originals 8001h or 8000h
// - byte form: overflow set only for originals 81h or 80h
// - double-decrement leaves oscillator-off, core-halt and irq-enable bits alone
// - interrupt disable ANDs status word with inverted 08h constant
// - interrupt disable clears irq enable, keeps oscillator-off and core-halt
// - interrupt disable keeps negative, zero, carry and overflow flags
package cdd_pkg;
    localparam int DATA_W = 16;
    localparam int BYTE_W = 8;
    localparam int ADDR_W = 2;
    localparam int CMD_W = 3;
    localparam logic [ADDR_W-1:0] ADDR_DEST = 2'h0;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 2'h1;
    localparam logic [ADDR_W-1:0] ADDR_CMD = 2'h2;
    localparam logic [ADDR_W-1:0] ADDR_ORIG = 2'h3;
    localparam int CMD_DOUBLE_DEC_BIT = 0;
    localparam int CMD_IRQ_DISABLE_BIT = 1;
    localparam int CMD_BYTE_BIT = 2;
    localparam int POS_CARRY = 0;
    localparam int POS_ZERO = 1;
    localparam int POS_NEGATIVE = 2;
    localparam int POS_IRQ_ENABLE = 3;
    localparam int POS_CORE_HALT = 4;
    localparam int POS_OSC_OFF = 5;
    localparam int POS_OVERFLOW = 8;
    localparam logic [DATA_W-1:0] DECREMENT_STEP = 16'h0002;
    localparam logic [DATA_W-1:0] BORROW_LO = 16'h0000;
    localparam logic [DATA_W-1:0] BORROW_HI = 16'h0001;
    localparam logic [DATA_W-1:0] WORD_OVF_LO = 16'h8000;
    localparam logic [DATA_W-1:0] WORD_OVF_HI = 16'h8001;
    localparam logic [DATA_W-1:0] BYTE_OVF_LO = 16'h0080;
    localparam logic [DATA_W-1:0] BYTE_OVF_HI = 16'h0081;
    localparam logic [DATA_W-1:0] IRQ_ENABLE_CONST = 16'h0008;
    localparam logic [DATA_W-1:0] DEST_RESET = 16'h0000;
    localparam logic [DATA_W-1:0] STATUS_RESET = 16'h0000;

    typedef struct packed {
        logic overflow;
        logic negative;
        logic zero;
        logic carry;
    } cdd_flags_type;

    typedef struct packed {
        logic [DATA_W-1:0] result;
        cdd_flags_type flags;
    } cdd_alu_out_type;

    typedef struct packed {
        logic [DATA_W-1:0] dest;
        logic [DATA_W-1:0] status_word;
        logic [DATA_W-1:0] orig;
        logic [CMD_W-1:0] last_cmd;
        logic [DATA_W-1:0] rdata;
    } cdd_state_type;

    localparam cdd_state_type STATE_RESET = '{
        dest: DEST_RESET,
        status_word: STATUS_RESET,
        orig: DEST_RESET,
        last_cmd: '0,
        rdata: '0
    };
endpackage

// ### logic/cdd_dec2.sv
// leaf: subtract-two arithmetic and flag generation for word and byte operands
`timescale 1ns/1ps
module cdd_dec2
    import cdd_pkg::*;
(
    input wire logic [DATA_W-1:0] operand,
    input wire logic byte_mode,
    output cdd_alu_out_type alu_out
);
    logic [DATA_W-1:0] word_diff;
    logic [BYTE_W-1:0] byte_diff;
    logic [DATA_W-1:0] low_byte;

    // one of two adjacent values; serves zero, borrow and both overflow windows
    function automatic logic in_pair(
        input logic [DATA_W-1:0] value,
        input logic [DATA_W-1:0] low,
        input logic [DATA_W-1:0] high
    );
        return (value == low) || (value == high);
    endfunction

    always_comb begin
        word_diff = operand - DECREMENT_STEP;
        byte_diff = operand[BYTE_W-1:0] - DECREMENT_STEP[BYTE_W-1:0];
        low_byte = {{(DATA_W-BYTE_W){1'b0}}, operand[BYTE_W-1:0]};
        if (byte_mode) begin
            // high byte cleared, as a byte write to a register does
            alu_out.result = {{(DATA_W-BYTE_W){1'b0}}, byte_diff};
            alu_out.flags.negative = byte_diff[BYTE_W-1];
            alu_out.flags.zero = in_pair(low_byte, DECREMENT_STEP, DECREMENT_STEP);
            alu_out.flags.carry = !in_pair(low_byte, BORROW_LO, BORROW_HI);
            alu_out.flags.overflow = in_pair(low_byte, BYTE_OVF_LO, BYTE_OVF_HI);
        end else begin
            alu_out.result = word_diff;
            alu_out.flags.negative = word_diff[DATA_W-1];
            alu_out.flags.zero = in_pair(operand, DECREMENT_STEP, DECREMENT_STEP);
            alu_out.flags.carry = !in_pair(operand, BORROW_LO, BORROW_HI);
            alu_out.flags.overflow = in_pair(operand, WORD_OVF_LO, WORD_OVF_HI);
        end
    end
endmodule

// ### logic/cdd_core.sv
// top: register-driven datapath for double-decrement and interrupt disable
`timescale 1ns/1ps
module cdd_core
    import cdd_pkg::*;
(
    input wire logic CLOCK,
    input wire logic RST_N,
    input wire logic [ADDR_W-1:0] ADDR,
    input wire logic [DATA_W-1:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [DATA_W-1:0] RDATA,
    output logic GLOBAL_IRQ_ENABLE,
    output logic CORE_HALT,
    output logic OSCILLATOR_OFF
);
    cdd_state_type state;
    cdd_state_type next_state;
    cdd_alu_out_type alu_out;
    logic cmd_write;
    logic double_decrement_op;
    logic interrupt_disable_op;
    logic byte_mode;

    // commands come only from a write to the command word
    assign cmd_write = WR && (ADDR == ADDR_CMD);
    assign double_decrement_op = cmd_write && WDATA[CMD_DOUBLE_DEC_BIT];
    assign interrupt_disable_op = cmd_write && WDATA[CMD_IRQ_DISABLE_BIT];
    assign byte_mode = WDATA[CMD_BYTE_BIT];

    cdd_dec2 u_dec2 (
        .operand(state.dest),
        .byte_mode(byte_mode),
        .alu_out(alu_out)
    );

    // merges the four arithmetic flags, every other bit passes through
    function automatic logic [DATA_W-1:0] merge_flags(
        input logic [DATA_W-1:0] word,
        input cdd_flags_type flags
    );
        logic [DATA_W-1:0] merged;
        merged = word;
        merged[POS_CARRY] = flags.carry;
        merged[POS_ZERO] = flags.zero;
        merged[POS_NEGATIVE] = flags.negative;
        merged[POS_OVERFLOW] = flags.overflow;
        return merged;
    endfunction

    always_comb begin
        next_state = state;
        next_state.rdata = '0;
        if (RD) begin
            case (ADDR)
                ADDR_DEST: begin
                    next_state.rdata = state.dest;
                end
                ADDR_STATUS: begin
                    next_state.rdata = state.status_word;
                end
                ADDR_CMD: begin
                    next_state.rdata = {{(DATA_W-CMD_W){1'b0}}, state.last_cmd};
                end
                ADDR_ORIG: begin
                    next_state.rdata = state.orig;
                end
                default: begin
                    next_state.rdata = '0;
                end
            endcase
        end
        if (WR) begin
            case (ADDR)
                ADDR_DEST: begin
                    next_state.dest = WDATA;
                end
                ADDR_STATUS: begin
                    next_state.status_word = WDATA;
                end
                ADDR_CMD: begin
                    next_state.last_cmd = WDATA[CMD_W-1:0];
                end
                default: begin
                    next_state.orig = state.orig;
                end
            endcase
        end
        if (double_decrement_op) begin
            next_state.orig = state.dest;
            next_state.dest = alu_out.result;
            // mode bits are not in the merge, so they keep their value
            next_state.status_word = merge_flags(state.status_word, alu_out.flags);
        end
        if (interrupt_disable_op) begin
            // applied after the flag merge so a combined command keeps both effects
            next_state.status_word = next_state.status_word & ~IRQ_ENABLE_CONST;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            state <= STATE_RESET;
        end else begin
            state <= next_state;
        end
    end

    assign RDATA = state.rdata;
    assign GLOBAL_IRQ_ENABLE = state.status_word[POS_IRQ_ENABLE];
    assign CORE_HALT = state.status_word[POS_CORE_HALT];
    assign OSCILLATOR_OFF = state.status_word[POS_OSC_OFF];

    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (!RST_N);

    sequence s_dd_word;
        double_decrement_op && !byte_mode && !interrupt_disable_op;
    endsequence

    sequence s_dd_byte;
        double_decrement_op && byte_mode && !interrupt_disable_op;
    endsequence

    sequence s_dd_any;
        double_decrement_op && !interrupt_disable_op;
    endsequence

    sequence s_idis_only;
        interrupt_disable_op && !double_decrement_op;
    endsequence

    sequence s_quiet;
        !WR;
    endsequence

    sequence s_wr_dest;
        WR && ADDR == ADDR_DEST;
    endsequence

    sequence s_wr_status;
        WR && ADDR == ADDR_STATUS;
    endsequence

    sequence s_wr_orig;
        WR && ADDR == ADDR_ORIG;
    endsequence

    sequence s_cmd_idle;
        cmd_write && !double_decrement_op && !interrupt_disable_op;
    endsequence

    property p_dest_word;
        s_dd_word |=> state.dest == 16'($past(state.dest) - DECREMENT_STEP);
    endproperty
    AST_DEST_WORD: assert property (p_dest_word)
        else $error("word double-decrement result wrong");

    property p_dest_byte;
        s_dd_byte |=> state.dest[BYTE_W-1:0] ==
            8'($past(state.dest[BYTE_W-1:0]) - DECREMENT_STEP[BYTE_W-1:0]);
    endproperty
    AST_DEST_BYTE: assert property (p_dest_byte)
        else $error("byte double-decrement result wrong");

    property p_byte_high_clear;
        s_dd_byte |=> state.dest[DATA_W-1:BYTE_W] == '0;
    endproperty
    AST_BYTE_HIGH_CLEAR: assert property (p_byte_high_clear)
        else $error("byte double-decrement left high byte set");

    property p_orig_capture;
        double_decrement_op |=> state.orig == $past(state.dest);
    endproperty
    AST_ORIG_CAPTURE: assert property (p_orig_capture)
        else $error("original operand not kept");

    property p_neg_word;
        s_dd_word |=> state.status_word[POS_NEGATIVE] == state.dest[DATA_W-1];
    endproperty
    AST_NEG_WORD: assert property (p_neg_word)
        else $error("word negative flag does not follow result");

    property p_neg_byte;
        s_dd_byte |=> state.status_word[POS_NEGATIVE] == state.dest[BYTE_W-1];
    endproperty
    AST_NEG_BYTE: assert property (p_neg_byte)
        else $error("byte negative flag does not follow bit 7");

    property p_zero_word;
        s_dd_word |=> state.status_word[POS_ZERO] == (state.orig == DECREMENT_STEP);
    endproperty
    AST_ZERO_WORD: assert property (p_zero_word)
        else $error("word zero flag wrong");

    property p_zero_byte;
        s_dd_byte |=> state.status_word[POS_ZERO] ==
            (state.orig[BYTE_W-1:0] == DECREMENT_STEP[BYTE_W-1:0]);
    endproperty
    AST_ZERO_BYTE: assert property (p_zero_byte)
        else $error("byte zero flag wrong");

    property p_zero_result;
        s_dd_any |=> state.status_word[POS_ZERO] == (state.dest == '0);
    endproperty
    AST_ZERO_RESULT: assert property (p_zero_result)
        else $error("zero flag disagrees with stored result");

    property p_carry_word;
        s_dd_word |=> state.status_word[POS_CARRY] == (state.orig[DATA_W-1:1] != '0);
    endproperty
    AST_CARRY_WORD: assert property (p_carry_word)
        else $error("word carry flag wrong");

    property p_carry_byte;
        s_dd_byte |=> state.status_word[POS_CARRY] == (state.orig[BYTE_W-1:1] != '0);
    endproperty
    AST_CARRY_BYTE: assert property (p_carry_byte)
        else $error("byte carry flag wrong");

    property p_ovf_word;
        s_dd_word |=> state.status_word[POS_OVERFLOW] ==
            (state.orig == WORD_OVF_LO || state.orig == WORD_OVF_HI);
    endproperty
    AST_OVF_WORD: assert property (p_ovf_word)
        else $error("word overflow flag wrong");

    property p_ovf_sign_word;
        s_dd_word |=> state.status_word[POS_OVERFLOW] ==
            (state.orig[DATA_W-1] && !state.dest[DATA_W-1]);
    endproperty
    AST_OVF_SIGN_WORD: assert property (p_ovf_sign_word)
        else $error("word overflow disagrees with sign change");

    property p_ovf_byte;
        s_dd_byte |=> state.status_word[POS_OVERFLOW] ==
            (state.orig[BYTE_W-1:0] == BYTE_OVF_LO[BYTE_W-1:0] ||
             state.orig[BYTE_W-1:0] == BYTE_OVF_HI[BYTE_W-1:0]);
    endproperty
    AST_OVF_BYTE: assert property (p_ovf_byte)
        else $error("byte overflow flag wrong");

    property p_dd_mode_keep;
        s_dd_any |=> GLOBAL_IRQ_ENABLE == $past(GLOBAL_IRQ_ENABLE) &&
            CORE_HALT == $past(CORE_HALT) && OSCILLATOR_OFF == $past(OSCILLATOR_OFF);
    endproperty
    AST_DD_MODE_KEEP: assert property (p_dd_mode_keep)
        else $error("double-decrement disturbed a mode bit");

    property p_idis_mask;
        s_idis_only |=> state.status_word == ($past(state.status_word) & ~IRQ_ENABLE_CONST);
    endproperty
    AST_IDIS_MASK: assert property (p_idis_mask)
        else $error("interrupt disable did not apply the mask");

    property p_idis_off;
        interrupt_disable_op ##1 s_quiet [*2] |-> !GLOBAL_IRQ_ENABLE;
    endproperty
    AST_IDIS_OFF: assert property (p_idis_off)
        else $error("irq enable not held low after disable");

    property p_idis_mode_keep;
        interrupt_disable_op |=> CORE_HALT == $past(CORE_HALT) &&
            OSCILLATOR_OFF == $past(OSCILLATOR_OFF);
    endproperty
    AST_IDIS_MODE_KEEP: assert property (p_idis_mode_keep)
        else $error("interrupt disable disturbed a mode bit");

    property p_idis_flags_keep;
        s_idis_only |=>
            state.status_word[POS_CARRY] == $past(state.status_word[POS_CARRY]) &&
            state.status_word[POS_ZERO] == $past(state.status_word[POS_ZERO]) &&
            state.status_word[POS_NEGATIVE] == $past(state.status_word[POS_NEGATIVE]) &&
            state.status_word[POS_OVERFLOW] == $past(state.status_word[POS_OVERFLOW]);
    endproperty
    AST_IDIS_FLAGS_KEEP: assert property (p_idis_flags_keep)
        else $error("interrupt disable changed an arithmetic flag");

    property p_idis_dest_keep;
        s_idis_only |=> state.dest == $past(state.dest);
    endproperty
    AST_IDIS_DEST_KEEP: assert property (p_idis_dest_keep)
        else $error("interrupt disable changed the destination");

    property p_combined;
        double_decrement_op && interrupt_disable_op |=>
            !GLOBAL_IRQ_ENABLE && state.status_word[POS_ZERO] == (state.dest == '0);
    endproperty
    AST_COMBINED: assert property (p_combined)
        else $error("combined command lost one of its effects");

    property p_read_dest;
        RD && ADDR == ADDR_DEST && !WR ##1 s_quiet |-> RDATA == $past(state.dest);
    endproperty
    AST_READ_DEST: assert property (p_read_dest)
        else $error("destination readback wrong");

    property p_read_status;
        RD && ADDR == ADDR_STATUS |=> RDATA == $past(state.status_word);
    endproperty
    AST_READ_STATUS: assert property (p_read_status)
        else $error("status word readback wrong");

    property p_idle_read;
        !RD |=> RDATA == '0;
    endproperty
    AST_IDLE_READ: assert property (p_idle_read)
        else $error("read data not zero outside a read");

    property p_write_dest;
        s_wr_dest |=> state.dest == $past(WDATA);
    endproperty
    AST_WRITE_DEST: assert property (p_write_dest)
        else $error("destination write did not land");

    property p_write_status;
        s_wr_status |=> state.status_word == $past(WDATA);
    endproperty
    AST_WRITE_STATUS: assert property (p_write_status)
        else $error("status word write did not land");

    // saved original only moves on a double-decrement
    property p_orig_read_only;
        s_wr_orig |=> state.orig == $past(state.orig) && state.dest == $past(state.dest);
    endproperty
    AST_ORIG_READ_ONLY: assert property (p_orig_read_only)
        else $error("write to saved original changed state");

    property p_cmd_idle;
        s_cmd_idle |=> state.dest == $past(state.dest) && state.status_word == $past(state.status_word);
    endproperty
    AST_CMD_IDLE: assert property (p_cmd_idle)
        else $error("empty command changed destination or status");

    property p_status_hold;
        !WR |=> $stable(state.status_word);
    endproperty
    AST_STATUS_HOLD: assert property (p_status_hold)
        else $error("status word moved without a write");

    // each command must use the destination left by the one before
    property p_dd_twice;
        s_dd_word ##1 s_dd_word |=> state.dest == 16'($past(state.dest, 2) - DECREMENT_STEP - DECREMENT_STEP);
    endproperty
    AST_DD_TWICE: assert property (p_dd_twice)
        else $error("back-to-back decrements lost a step");

    property p_dd_other_bits;
        s_dd_any |=>
            state.status_word[DATA_W-1:POS_OVERFLOW+1] == $past(state.status_word[DATA_W-1:POS_OVERFLOW+1]) &&
            state.status_word[POS_OVERFLOW-1:POS_NEGATIVE+1] ==
            $past(state.status_word[POS_OVERFLOW-1:POS_NEGATIVE+1]);
    endproperty
    AST_DD_OTHER_BITS: assert property (p_dd_other_bits)
        else $error("double-decrement touched a non-flag status bit");
endmodule

// ### verif/cdd_core_tb.sv
// self-checking bench for the double-decrement and interrupt-disable datapath
`timescale 1ns/1ps
module cdd_core_tb
    import cdd_pkg::*;
();
    typedef struct packed {
        logic [DATA_W-1:0] value;
        logic [DATA_W-1:0] mask;
    } cdd_note_type;

    logic CLOCK = 1'b0;
    logic RST_N = 1'b0;
    logic [ADDR_W-1:0] ADDR = '0;
    logic [DATA_W-1:0] WDATA = '0;
    logic WR = 1'b0;
    logic RD = 1'b0;
    logic [DATA_W-1:0] RDATA;
    logic GLOBAL_IRQ_ENABLE;
    logic CORE_HALT;
    logic OSCILLATOR_OFF;
    logic [DATA_W-1:0] m_dest = '0;
    logic [DATA_W-1:0] m_stat = '0;
    logic [DATA_W-1:0] m_orig = '0;
    logic [CMD_W-1:0] m_cmd = '0;
    logic [DATA_W-1:0] stat_q = '0;
    logic rd_q = 1'b0;
    cdd_note_type notes[$];
    int fails = 0;
    int n_compared = 0;
    int cycles = 0;

    always #5 CLOCK = ~CLOCK;

    cdd_core u_dut (
        .CLOCK(CLOCK),
        .RST_N(RST_N),
        .ADDR(ADDR),
        .WDATA(WDATA),
        .WR(WR),
        .RD(RD),
        .RDATA(RDATA),
        .GLOBAL_IRQ_ENABLE(GLOBAL_IRQ_ENABLE),
        .CORE_HALT(CORE_HALT),
        .OSCILLATOR_OFF(OSCILLATOR_OFF)
    );

    task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_sim;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // reference model, updated by nba so it lands with the bus edge
    task automatic apply(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        logic [DATA_W-1:0] s;
        logic [DATA_W-1:0] o;
        logic [DATA_W-1:0] r;
        logic [BYTE_W-1:0] b;
        s = m_stat;
        o = m_dest;
        if (a == ADDR_DEST) m_dest <= d;
        if (a == ADDR_STATUS) m_stat <= d;
        if (a == ADDR_CMD) begin
            m_cmd <= d[CMD_W-1:0];
            if (d[CMD_DOUBLE_DEC_BIT] && d[CMD_BYTE_BIT]) begin
                b = o[7:0] - 8'h02;
                r = {8'h00, b};
                s[POS_NEGATIVE] = b[7];
                s[POS_ZERO] = (o[7:0] == 8'h02);
                s[POS_CARRY] = (o[7:0] > 8'h01);
                s[POS_OVERFLOW] = (o[7:0] == 8'h80) || (o[7:0] == 8'h81);
            end else begin
                r = o - 16'h0002;
                s[POS_NEGATIVE] = r[15];
                s[POS_ZERO] = (o == 16'h0002);
                s[POS_CARRY] = (o > 16'h0001);
                s[POS_OVERFLOW] = (o == 16'h8000) || (o == 16'h8001);
            end
            if (!d[CMD_DOUBLE_DEC_BIT]) s = m_stat;
            if (d[CMD_DOUBLE_DEC_BIT]) m_dest <= r;
            if (d[CMD_DOUBLE_DEC_BIT]) m_orig <= o;
            if (d[CMD_IRQ_DISABLE_BIT]) s = s & ~16'h0008;
            m_stat <= s;
        end
    endtask

    // one bus cycle; strobes are held until the next call replaces them
    task automatic op(input logic w, input logic r, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        cdd_note_type n;
        @(posedge CLOCK);
        WR <= w;
        RD <= r;
        ADDR <= a;
        WDATA <= d;
        if (r) begin
            n.mask = (a == ADDR_CMD) ? 16'h0007 : 16'hffff;
            n.value = (a == ADDR_DEST) ? m_dest : (a == ADDR_STATUS) ? m_stat :
                      (a == ADDR_ORIG) ? m_orig : {13'h0000, m_cmd};
            notes.push_back(n);
        end
        if (w) apply(a, d);
    endtask

    task automatic do_reset;
        op(1'b0, 1'b0, '0, '0);
        @(posedge CLOCK);
        RST_N <= 1'b0;
        m_dest <= '0;
        m_stat <= '0;
        m_orig <= '0;
        m_cmd <= '0;
        repeat (4) @(posedge CLOCK);
        RST_N <= 1'b1;
    endtask

    task automatic dec_case(input logic [DATA_W-1:0] v, input logic [DATA_W-1:0] cmd);
        op(1'b1, 1'b0, ADDR_STATUS, 16'($urandom));
        op(1'b1, 1'b0, ADDR_DEST, v);
        op(1'b1, 1'b0, ADDR_CMD, cmd);
        op(1'b0, 1'b1, ADDR_DEST, '0);
        op(1'b0, 1'b1, ADDR_ORIG, '0);
        op(1'b0, 1'b1, ADDR_STATUS, '0);
        op(1'b0, 1'b1, ADDR_CMD, '0);
    endtask

    // result watcher: rdata lives only in the cycle after the read strobe
    always @(posedge CLOCK) begin
        cdd_note_type n;
        cycles++;
        if (cycles > 1 && rd_q && notes.size() > 0) begin
            n = notes.pop_front();
            check(RDATA & n.mask, n.value & n.mask);
        end else if (cycles > 1) begin
            check(RDATA, 16'h0000);
        end
        if (cycles > 1) begin
            check({13'h0000, OSCILLATOR_OFF, CORE_HALT, GLOBAL_IRQ_ENABLE}, {13'h0000, stat_q[5:3]});
        end
        rd_q <= RD;
        stat_q <= m_stat;
        // last in the process, so nothing runs after the finish
        if (cycles > 3000) begin
            fails++;
            end_sim();
        end
    end

    initial begin
        logic [DATA_W-1:0] wv [0:8] = '{16'h0000, 16'h0001, 16'h0002, 16'h0003, 16'h7fff,
                                        16'h8000, 16'h8001, 16'h8002, 16'hffff};
        logic [BYTE_W-1:0] bv [0:7] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h7f, 8'h80, 8'h81, 8'h82};
        logic [DATA_W-1:0] v;
        void'($urandom(94));
        repeat (4) @(posedge CLOCK);
        RST_N <= 1'b1;
        for (int a = 0; a < 4; a++) op(1'b0, 1'b1, a[ADDR_W-1:0], '0);
        for (int i = 0; i < 12; i++) begin
            v = (i < 9) ? wv[i] : 16'($urandom);
            dec_case(v, 16'h0001);
        end
        for (int i = 0; i < 8; i++) begin
            v = 16'($urandom);
            v[7:0] = bv[i];
            dec_case(v, 16'h0005);
        end
        // every command code, incl. disable alone and combined with the decrement
        for (int i = 0; i < 8; i++) dec_case(16'($urandom), 16'(i));
        // back-to-back decrements through zero into borrow
        op(1'b1, 1'b0, ADDR_DEST, 16'h0004);
        op(1'b1, 1'b0, ADDR_CMD, 16'h0001);
        op(1'b1, 1'b0, ADDR_CMD, 16'h0001);
        op(1'b1, 1'b0, ADDR_CMD, 16'h0001);
        op(1'b0, 1'b1, ADDR_DEST, '0);
        op(1'b0, 1'b1, ADDR_STATUS, '0);
        // disable leaves every other status bit set
        op(1'b1, 1'b0, ADDR_STATUS, 16'hffff);
        op(1'b1, 1'b0, ADDR_CMD, 16'h0002);
        op(1'b0, 1'b0, '0, '0); // no-operation pad after the disable
        op(1'b0, 1'b1, ADDR_STATUS, '0);
        // saved original is read-only
        op(1'b1, 1'b0, ADDR_ORIG, 16'h1234);
        op(1'b0, 1'b1, ADDR_ORIG, '0);
        do_reset();
        for (int a = 0; a < 4; a++) op(1'b0, 1'b1, a[ADDR_W-1:0], '0);
        op(1'b0, 1'b0, '0, '0);
        repeat (4) @(posedge CLOCK);
        end_sim();
    end
endmodule
